// File: logic/rate_bandwidth_cmd_checker.sv
// rate, aperture, bandwidth and filter command checker with apb registers
//
// Contract
// - line-cycle rate accepted from 0.01 to 60 (60 Hz) or 50 (50 Hz).
// - aperture accepted from 1.67e-4 s (60 Hz) or 2e-4 s (50 Hz) to 1 s.
// - aperture resets to 16.67 ms on 60 Hz mains, 20 ms on 50 Hz.
// - each of seven functions holds its own line-cycle rate, default 5.0.
// - aperture and line-cycle forms are equivalent; each updates the other. code: reset gives 5.0 with 16.67 ms; mains change sets aperture only.
// - bandwidth 3-29 gives band 3, 30-299 band 30, 300-300e3 band 300.
// - bandwidth up to 10e6 accepted, anything above 300e3 still gives band 300.
// - ac rate command under band 3 or 30 gives conflict -221, no change.
// - ac rate command under band 300 is accepted.
// - ac bandwidth resets to band 30; host selects 300 before ac rates.
// - channel list entry not set to the command's function gives -221.
// - a first:last channel range is walked channel by channel in its slot.
// - dc voltage and current commands act the same with or without dc header.
// - reading is average of 1 to 100 consecutive conversions per filter count.
// - filter setup kept per function and restored when function reselected.
module rate_bandwidth_cmd_checker
  import rate_bw_pkg::*;
#(
  parameter int AW    = 12,
  parameter int DW    = 24,
  parameter int NSLOT = 5,
  parameter int NCH   = 20
)(
  // clock and reset
  input  wire logic          clk,
  input  wire logic          rstn,
  // apb slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [AW-1:0] paddr,
  input  wire logic [31:0]   pwdata,
  input  wire logic [3:0]    pstrb,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  // conversions in, filtered readings out
  input  wire logic          conv_valid,
  input  wire logic [DW-1:0] conv_data,
  output logic               reading_valid,
  output logic [DW-1:0]      reading_data,
  // interrupt
  output logic               irq
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  localparam int NCHAN = NSLOT * NCH;

  function automatic logic [33:0] div_step(input logic [32:0] rem, input logic in_bit,
                                           input logic [31:0] d);
    logic [32:0] t;
    t = {rem[31:0], in_bit};
    if (t >= {1'b0, d})
      div_step = {t - {1'b0, d}, 1'b1};
    else
      div_step = {t, 1'b0};
  endfunction

  function automatic logic [$clog2(NCHAN)-1:0] chan_idx(input logic [2:0] slot,
                                                        input logic [6:0] ch);
    int i;
    i = (int'(slot) - 1) * NCH + int'(ch) - 1;
    chan_idx = i[$clog2(NCHAN)-1:0];
  endfunction

  function automatic logic chan_ok(input logic [2:0] slot, input logic [6:0] ch);
    chan_ok = (slot >= 3'h1) && (int'(slot) <= NSLOT) && (ch >= 7'h01) && (int'(ch) <= NCH);
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef enum {S_IDLE, S_CHECK, S_SCAN, S_APPLY, S_DIV, S_DIVDONE, S_FINISH} eng_e;
  typedef enum {FL_ACC, FL_DIV} flt_e;

  eng_e         state_r;
  flt_e         fstate_r;
  cmd_s         cmd_r;
  clist_s       cl_r;
  logic [31:0]  val_r;
  logic [6:0]   ch_r;
  err_e         err_r;
  logic [5:0]   step_r;
  logic [32:0]  rem_r;
  logic [31:0]  quo_r;
  logic [31:0]  dvd_r;
  logic         mains50_r;
  logic [2:0]   act_r;
  logic [2:0]   rdsel_r;
  logic [ST_W-1:0] status_r;
  logic [ST_W-1:0] mask_r;
  logic [15:0]  errcode_r;
  logic [12:0]  nplc_r [NFUNC];
  logic [23:0]  aper_r [NFUNC];
  logic [8:0]   bw_r   [NFUNC];
  fcfg_s        fcfg_r [NFUNC];
  logic [2:0]   chfunc_r [NCHAN];
  logic [31:0]  acc_r;
  logic [6:0]   n_r;
  logic [32:0]  frem_r;
  logic [31:0]  fquo_r;
  logic [31:0]  fdvd_r;
  logic [5:0]   fstep_r;
  logic         fneg_r;

  logic         wr_en;
  logic         rd_en;
  logic [7:0]   ofs;
  logic         mapped;
  logic         busy;
  logic [33:0]  dstep;
  logic [33:0]  fstep;
  logic [2:0]   cf;
  fcfg_s        afcfg;
  logic [31:0]  sum_nxt;
  logic [ST_W-1:0] st_set;

  assign ofs    = paddr[7:0];
  assign mapped = (paddr[AW-1:8] == '0) && (ofs[1:0] == 2'h0) && (ofs <= OFS_RESULT);
  assign wr_en  = psel && penable && pready && pwrite && mapped;
  assign rd_en  = psel && penable && !pready && !pwrite;
  assign busy   = (state_r != S_IDLE);
  assign cf     = cmd_r.func;
  assign dstep  = div_step(rem_r, dvd_r[31], quo_r[31:0] == quo_r ? {8'h00, 13'h0000,
                  mains50_r ? PLC_UNIT50 : PLC_UNIT60} : 32'h0000_0000);
  assign fstep  = div_step(frem_r, fdvd_r[31], {25'h000_0000, afcfg.cnt});
  assign afcfg  = fcfg_r[act_r];
  assign sum_nxt = acc_r + 32'(signed'(conv_data));

  // ---------------------------------------------------------------
  // apb slave
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready &&
                 (!mapped || (pwrite && paddr[7:0] == OFS_CMD && busy));
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
      prdata <= 32'h0000_0000;
    else if (rd_en)
    begin
      unique case (ofs)
        OFS_CTRL:   prdata <= {25'h000_0000, act_r, 3'h0, mains50_r};
        OFS_CMD:    prdata <= {22'h00_0000, cmd_r.dc_hdr, cmd_r.clist_en, 2'h0, cmd_r.kind,
                               1'b0, cmd_r.func};
        OFS_VALUE:  prdata <= val_r;
        OFS_CLIST:  prdata <= {9'h000, cl_r.last, 1'b0, cl_r.first, 5'h00, cl_r.slot};
        OFS_STATUS: prdata <= {28'h000_0000, status_r};
        OFS_MASK:   prdata <= {28'h000_0000, mask_r};
        OFS_ERR:    prdata <= {busy, 15'h0000, errcode_r};
        OFS_RDSEL:  prdata <= {29'h0000_0000, rdsel_r};
        OFS_RDNPLC: prdata <= (rdsel_r < 3'h7) ? {19'h0_0000, nplc_r[rdsel_r]} : 32'h0000_0000;
        OFS_RDAPER: prdata <= (rdsel_r < 3'h7) ? {8'h00, aper_r[rdsel_r]} : 32'h0000_0000;
        OFS_RDBWF:  prdata <= (rdsel_r < 3'h7) ? {7'h00, fcfg_r[rdsel_r].en, 1'b0,
                               fcfg_r[rdsel_r].cnt, 7'h00, bw_r[rdsel_r]} : 32'h0000_0000;
        OFS_RESULT: prdata <= {8'h00, reading_data};
        default:    prdata <= 32'h0000_0000;
      endcase
    end
  end

  // control, selection and mask registers
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      mains50_r <= 1'b0;
      act_r     <= 3'h0;
      rdsel_r   <= 3'h0;
      mask_r    <= '0;
    end
    else if (wr_en && pstrb[0])
    begin
      if (ofs == OFS_CTRL)
      begin
        mains50_r <= pwdata[CTRL_MAINS50];
        act_r     <= (pwdata[6:4] < 3'h7) ? pwdata[6:4] : act_r;
      end
      if (ofs == OFS_RDSEL)
        rdsel_r <= pwdata[2:0];
      if (ofs == OFS_MASK)
        mask_r <= pwdata[ST_W-1:0];
    end
  end

  // channel function table
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < NCHAN; i++)
        chfunc_r[i] <= CH_NONE;
    end
    else if (wr_en && ofs == OFS_CHFUNC && chan_ok(pwdata[2:0], pwdata[CHF_CH +: 7]))
      chfunc_r[chan_idx(pwdata[2:0], pwdata[CHF_CH +: 7])] <= pwdata[CHF_FUNC +: 3];
  end

  // ---------------------------------------------------------------
  // status, error code and interrupt
  // ---------------------------------------------------------------
  always_comb
  begin
    st_set = '0;
    if (state_r == S_FINISH)
    begin
      st_set[ST_DONE]     = 1'b1;
      st_set[ST_CONFLICT] = (err_r == E_CONFLICT);
      st_set[ST_PARAM]    = (err_r == E_PARAM);
    end
    st_set[ST_READING] = reading_valid;
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      status_r  <= '0;
      errcode_r <= ERR_CODE_NONE;
      irq       <= 1'b0;
    end
    else
    begin
      status_r <= (status_r & ~((wr_en && ofs == OFS_STATUS) ? pwdata[ST_W-1:0] : '0)) | st_set;
      irq      <= |(status_r & mask_r);
      if (state_r == S_FINISH)
        errcode_r <= (err_r == E_CONFLICT) ? ERR_CODE_CONFLICT :
                     (err_r == E_PARAM) ? ERR_CODE_PARAM : ERR_CODE_NONE;
    end
  end

  // ---------------------------------------------------------------
  // command engine
  // ---------------------------------------------------------------
  function automatic err_e check(input cmd_s c, input logic [31:0] v, input logic m50,
                                 input logic [8:0] bw, input clist_s cl);
    logic ac;
    ac = (c.func == F_ACV) || (c.func == F_ACI);
    check = E_NONE;
    if (c.func > F_TEMP)
      check = E_PARAM;
    else if (c.clist_en && (!chan_ok(cl.slot, cl.first) || !chan_ok(cl.slot, cl.last) ||
             cl.first > cl.last))
      check = E_PARAM;
    else
    begin
      unique case (c.kind)
        K_NPLC, K_APER:
          if (ac && bw != BAND_300)
            check = E_CONFLICT;
          else if (c.kind == K_NPLC && (v < NPLC_MIN || v > (m50 ? NPLC_MAX50 : NPLC_MAX60)))
            check = E_PARAM;
          else if (c.kind == K_APER && (v < (m50 ? APER_MIN50 : APER_MIN60) || v > APER_MAX))
            check = E_PARAM;
        K_BW:
          if (!ac)
            check = E_CONFLICT;
          else if (v < BW_MIN || v > BW_ACCEPT)
            check = E_PARAM;
        K_FILT:
          if ({25'h000_0000, v[6:0]} < FILT_MIN || {25'h000_0000, v[6:0]} > FILT_MAX)
            check = E_PARAM;
      endcase
    end
  endfunction

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      state_r <= S_IDLE;
      cmd_r   <= '0;
      val_r   <= 32'h0000_0000;
      cl_r    <= '0;
      ch_r    <= 7'h00;
      err_r   <= E_NONE;
      step_r  <= 6'h00;
      rem_r   <= '0;
      quo_r   <= 32'h0000_0000;
      dvd_r   <= 32'h0000_0000;
    end
    else
    begin
      if (wr_en && !busy && ofs == OFS_VALUE)
        val_r <= pwdata;
      if (wr_en && !busy && ofs == OFS_CLIST)
        cl_r <= {pwdata[2:0], pwdata[CLIST_FIRST +: 7], pwdata[CLIST_LAST +: 7]};
      unique case (state_r)
        S_IDLE:
          if (wr_en && ofs == OFS_CMD)
          begin
            // dc header flag carries no meaning
            cmd_r   <= {pwdata[CMD_DCHDR], pwdata[CMD_CLIST], kind_e'(pwdata[CMD_KIND +: 2]),
                        pwdata[2:0]};
            state_r <= S_CHECK;
          end
        S_CHECK:
        begin
          err_r <= check(cmd_r, val_r, mains50_r, (cf < 3'h7) ? bw_r[cf] : BAND_30, cl_r);
          ch_r  <= cl_r.first;
          if (check(cmd_r, val_r, mains50_r, (cf < 3'h7) ? bw_r[cf] : BAND_30, cl_r) != E_NONE)
            state_r <= S_FINISH;
          else
            state_r <= cmd_r.clist_en ? S_SCAN : S_APPLY;
        end
        S_SCAN:
        begin
          // listed channel must hold the function
          if (chfunc_r[chan_idx(cl_r.slot, ch_r)] != cf)
          begin
            err_r   <= E_CONFLICT;
            state_r <= S_FINISH;
          end
          else if (ch_r == cl_r.last)
            state_r <= S_APPLY;
          else
            ch_r <= ch_r + 7'h01;
        end
        S_APPLY:
        begin
          rem_r   <= '0;
          quo_r   <= 32'h0000_0000;
          dvd_r   <= val_r;
          step_r  <= 6'h00;
          state_r <= (cmd_r.kind == K_APER) ? S_DIV : S_FINISH;
        end
        // aperture over 0.01 line cycle gives line cycles in 0.01 PLC
        S_DIV:
        begin
          rem_r  <= dstep[33:1];
          quo_r  <= {quo_r[30:0], dstep[0]};
          dvd_r  <= {dvd_r[30:0], 1'b0};
          step_r <= step_r + 6'h01;
          if (step_r == DIV_LAST)
            state_r <= S_DIVDONE;
        end
        S_DIVDONE:
          state_r <= S_FINISH;
        S_FINISH:
          state_r <= S_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // per-function settings
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < NFUNC; i++)
      begin
        nplc_r[i] <= NPLC_DEF;
        aper_r[i] <= APER_DEF60;
        // ac bandwidth defaults to band 30
        bw_r[i]   <= BAND_30;
        fcfg_r[i] <= '{en: 1'b0, cnt: FILT_CNT_DEF};
      end
    end
    else
    begin
      if (wr_en && pstrb[0] && ofs == OFS_CTRL && pwdata[CTRL_MAINS50] != mains50_r)
      begin
        for (int i = 0; i < NFUNC; i++)
          aper_r[i] <= pwdata[CTRL_MAINS50] ? APER_DEF50 : APER_DEF60;
      end
      else if (state_r == S_APPLY)
      begin
        unique case (cmd_r.kind)
          K_NPLC:
          begin
            nplc_r[cf] <= val_r[12:0];
            aper_r[cf] <= 24'(val_r[12:0] * (mains50_r ? PLC_UNIT50 : PLC_UNIT60));
          end
          K_APER:
            aper_r[cf] <= val_r[23:0];
          // above range clamps to top band
          K_BW:
            bw_r[cf] <= (val_r < BW_MID) ? BAND_3 : (val_r < BW_HIGH) ? BAND_30 : BAND_300;
          K_FILT:
            fcfg_r[cf] <= '{en: val_r[FILT_EN_BIT], cnt: val_r[6:0]};
        endcase
      end
      else if (state_r == S_DIVDONE)
        nplc_r[cf] <= (quo_r[31:13] != '0) ? 13'h1FFF : quo_r[12:0];
    end
  end

  // ---------------------------------------------------------------
  // averaging filter
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      fstate_r      <= FL_ACC;
      acc_r         <= 32'h0000_0000;
      n_r           <= 7'h00;
      frem_r        <= '0;
      fquo_r        <= 32'h0000_0000;
      fdvd_r        <= 32'h0000_0000;
      fstep_r       <= 6'h00;
      fneg_r        <= 1'b0;
      reading_valid <= 1'b0;
      reading_data  <= '0;
    end
    else
    begin
      reading_valid <= 1'b0;
      // function change restarts with that function's setup
      if (wr_en && pstrb[0] && ofs == OFS_CTRL && pwdata[6:4] != act_r)
      begin
        fstate_r <= FL_ACC;
        acc_r    <= 32'h0000_0000;
        n_r      <= 7'h00;
      end
      else
      begin
        unique case (fstate_r)
          FL_ACC:
            if (conv_valid && !afcfg.en)
            begin
              reading_valid <= 1'b1;
              reading_data  <= conv_data;
            end
            else if (conv_valid && n_r + 7'h01 >= afcfg.cnt)
            begin
              fneg_r   <= sum_nxt[31];
              fdvd_r   <= sum_nxt[31] ? 32'h0000_0000 - sum_nxt : sum_nxt;
              frem_r   <= '0;
              fquo_r   <= 32'h0000_0000;
              fstep_r  <= 6'h00;
              fstate_r <= FL_DIV;
              acc_r    <= 32'h0000_0000;
              n_r      <= 7'h00;
            end
            else if (conv_valid)
            begin
              acc_r <= sum_nxt;
              n_r   <= n_r + 7'h01;
            end
          FL_DIV:
          begin
            frem_r  <= fstep[33:1];
            fquo_r  <= {fquo_r[30:0], fstep[0]};
            fdvd_r  <= {fdvd_r[30:0], 1'b0};
            fstep_r <= fstep_r + 6'h01;
            if (fstep_r == DIV_LAST)
            begin
              reading_valid <= 1'b1;
              reading_data  <= fneg_r ? DW'(32'h0000_0000 - {fquo_r[30:0], fstep[0]}) :
                               DW'({fquo_r[30:0], fstep[0]});
              fstate_r      <= FL_ACC;
            end
          end
        endcase
      end
    end
  end

endmodule // rate_bandwidth_cmd_checker

// File: logic/rate_bw_pkg.sv
// shared constants and types of the rate and bandwidth command checker
package rate_bw_pkg;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_CMD    = 8'h04;
  localparam logic [7:0] OFS_VALUE  = 8'h08;
  localparam logic [7:0] OFS_CLIST  = 8'h0C;
  localparam logic [7:0] OFS_CHFUNC = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_MASK   = 8'h18;
  localparam logic [7:0] OFS_ERR    = 8'h1C;
  localparam logic [7:0] OFS_RDSEL  = 8'h20;
  localparam logic [7:0] OFS_RDNPLC = 8'h24;
  localparam logic [7:0] OFS_RDAPER = 8'h28;
  localparam logic [7:0] OFS_RDBWF  = 8'h2C;
  localparam logic [7:0] OFS_RESULT = 8'h30;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int CTRL_MAINS50 = 0;
  localparam int CLIST_FIRST  = 8;
  localparam int CLIST_LAST   = 16;
  localparam int CHF_CH       = 8;
  localparam int CHF_FUNC     = 16;
  localparam int CMD_KIND     = 4;
  localparam int CMD_CLIST    = 8;
  localparam int CMD_DCHDR    = 9;
  localparam int FILT_EN_BIT  = 8;
  localparam int ST_DONE      = 0;
  localparam int ST_CONFLICT  = 1;
  localparam int ST_PARAM     = 2;
  localparam int ST_READING   = 3;
  localparam int ST_W         = 4;
  localparam int ERR_BUSY     = 31;

  // ---------------------------------------------------------------
  // value ranges: line cycles in 0.01 PLC, aperture in 0.1 us, bw in Hz
  // ---------------------------------------------------------------
  localparam logic [31:0] NPLC_MIN     = 32'h0000_0001;
  localparam logic [31:0] NPLC_MAX60   = 32'h0000_1770;
  localparam logic [31:0] NPLC_MAX50   = 32'h0000_1388;
  localparam logic [31:0] APER_MIN60   = 32'h0000_0686;
  localparam logic [31:0] APER_MIN50   = 32'h0000_07D0;
  localparam logic [31:0] APER_MAX     = 32'h0098_9680;
  localparam logic [31:0] BW_MIN       = 32'h0000_0003;
  localparam logic [31:0] BW_MID       = 32'h0000_001E;
  localparam logic [31:0] BW_HIGH      = 32'h0000_012C;
  localparam logic [31:0] BW_TOP       = 32'h0004_93E0;
  localparam logic [31:0] BW_ACCEPT    = 32'h0098_9680;
  localparam logic [31:0] FILT_MIN     = 32'h0000_0001;
  localparam logic [31:0] FILT_MAX     = 32'h0000_0064;
  localparam logic [10:0] PLC_UNIT60   = 11'h683;
  localparam logic [10:0] PLC_UNIT50   = 11'h7D0;

  // ---------------------------------------------------------------
  // values after reset and codes
  // ---------------------------------------------------------------
  localparam logic [12:0] NPLC_DEF     = 13'h01F4;
  localparam logic [23:0] APER_DEF60   = 24'h02_8B2C;
  localparam logic [23:0] APER_DEF50   = 24'h03_0D40;
  localparam logic [8:0]  BAND_3       = 9'h003;
  localparam logic [8:0]  BAND_30      = 9'h01E;
  localparam logic [8:0]  BAND_300     = 9'h12C;
  localparam logic [6:0]  FILT_CNT_DEF = 7'h01;
  localparam logic [15:0] ERR_CODE_CONFLICT = 16'hFF23;
  localparam logic [15:0] ERR_CODE_PARAM    = 16'hFF22;
  localparam logic [15:0] ERR_CODE_NONE     = 16'h0000;
  localparam logic [2:0]  CH_NONE      = 3'h7;
  localparam int          NFUNC        = 7;
  localparam logic [5:0]  DIV_LAST     = 6'h1F;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {F_DCV, F_ACV, F_DCI, F_ACI, F_RES2, F_RES4, F_TEMP} func_e;
  typedef enum logic [1:0] {K_NPLC, K_APER, K_BW, K_FILT} kind_e;
  typedef enum logic [1:0] {E_NONE, E_CONFLICT, E_PARAM} err_e;

  typedef struct packed {
    logic  dc_hdr;
    logic  clist_en;
    kind_e kind;
    logic [2:0] func;
  } cmd_s;

  typedef struct packed {
    logic [2:0] slot;
    logic [6:0] first;
    logic [6:0] last;
  } clist_s;

  typedef struct packed {
    logic       en;
    logic [6:0] cnt;
  } fcfg_s;

endpackage : rate_bw_pkg

// File: tb/conv_src.sv
// conversion source feeding pairs of samples to the filter
module conv_src
  import rate_bw_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        go,
  input  wire logic [23:0] v0,
  input  wire logic [23:0] v1,
  output logic             conv_valid,
  output logic [23:0]      conv_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] n_r;
  always_ff @(posedge clk)
  begin
    n_r        <= !rstn ? 2'h0 : go ? 2'h2 : n_r - (n_r != 2'h0);
    conv_valid <= rstn && (go || n_r == 2'h2);
    conv_data  <= !rstn ? 24'h0 : go ? v0 : n_r == 2'h2 ? v1 : ~conv_data;
  end
endmodule // conv_src

// File: tb/rbc_checker_properties.sv
// port checker for the rate and bandwidth command checker
module rbc_checker
  import rate_bw_pkg::*;
#(
  parameter int DW = 24
)(
  // clock and reset
  input wire logic          clk,
  input wire logic          rstn,
  // apb
  input wire logic          psel,
  input wire logic          penable,
  input wire logic [31:0]   prdata,
  input wire logic          pready,
  input wire logic          pslverr,
  // readings and interrupt
  input wire logic          reading_valid,
  input wire logic [DW-1:0] reading_data,
  input wire logic          irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  a_ready_second: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready too long");
  a_ready_qual: assert property (pready |-> psel && penable)
    else $error("pready without access");
  a_err_qual: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_rdata_hold: assert property (!pready |-> $stable(prdata))
    else $error("prdata moved");
  a_reading_hold: assert property (!reading_valid |-> $stable(reading_data))
    else $error("reading moved");
  a_reset_quiet: assert property (disable iff (1'b0) !rstn |=> !pready && !irq && !reading_valid)
    else $error("output active in reset");
  a_reset_data: assert property (disable iff (1'b0) !rstn |=> reading_data == '0 && prdata == '0)
    else $error("data not cleared");
  cover property (pslverr);
  cover property ($rose(irq));
  cover property (reading_valid);
endmodule // rbc_checker

bind rate_bandwidth_cmd_checker rbc_checker #(.DW(DW)) rbc_checker_i (.clk(clk), .rstn(rstn),
  .psel(psel), .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .reading_valid(reading_valid), .reading_data(reading_data), .irq(irq));

// File: tb/tb.sv
// self-checking bench for the rate and bandwidth command checker
module tb
  import rate_bw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rstn, psel, penable, pwrite, pready, pslverr, go, serr, cv, rv, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic [23:0] v0, v1, cd, rdat;
  int          error_cnt, total_checks;
  rate_bandwidth_cmd_checker rate_bandwidth_cmd_checker_i (.clk(clk), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .conv_valid(cv), .conv_data(cd),
    .reading_valid(rv), .reading_data(rdat), .irq(irq));
  conv_src conv_src_i (.clk(clk), .rstn(rstn), .go(go), .v0(v0), .v1(v1),
    .conv_valid(cv), .conv_data(cd));
  task automatic finish_test();
    if (error_cnt == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {4'h0, a};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic cmd(input logic [31:0] c, input logic [31:0] v, input logic [15:0] e);
    int n;
    apb(1'b1, OFS_VALUE, v);
    apb(1'b1, OFS_CMD, c);
    n = 0;
    do
    begin
      apb(1'b0, OFS_ERR, 32'h0);
      n++;
    end
    while (rd[ERR_BUSY] !== 1'b0 && n < 40);
    chk(rd, {16'h0, e});
  endtask
  task automatic conv(input logic [23:0] a, input logic [23:0] b, input logic [23:0] e);
    v0 <= a;
    v1 <= b;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    do
      @(posedge clk);
    while (rv !== 1'b1);
    chk({8'h0, rdat}, {8'h0, e});
  endtask
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    finish_test();
  end
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, go, v0, v1} = '0;
    pstrb = 4'hF;
    error_cnt = 0;
    total_checks = 0;
    rstn = 1'b0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rchk(OFS_RDNPLC, 32'd500);
    rchk(OFS_RDAPER, 32'd166700);
    apb(1'b1, OFS_RDSEL, 32'h1);
    rchk(OFS_RDBWF, 32'h0001_001E);
    cmd(32'h001, 32'd100, ERR_CODE_CONFLICT);
    rchk(OFS_STATUS, 32'h3);
    cmd(32'h003, 32'd100, ERR_CODE_CONFLICT);
    rchk(OFS_RDNPLC, 32'd500);
    cmd(32'h021, 32'd29, ERR_CODE_NONE);
    rchk(OFS_RDBWF, 32'h0001_0003);
    cmd(32'h021, 32'd299, ERR_CODE_NONE);
    rchk(OFS_RDBWF, 32'h0001_001E);
    cmd(32'h021, 32'd10000000, ERR_CODE_NONE);
    rchk(OFS_RDBWF, 32'h0001_012C);
    cmd(32'h021, 32'd2, ERR_CODE_PARAM);
    cmd(32'h001, 32'd6000, ERR_CODE_NONE);
    rchk(OFS_RDNPLC, 32'd6000);
    cmd(32'h001, 32'd6001, ERR_CODE_PARAM);
    cmd(32'h001, 32'd0, ERR_CODE_PARAM);
    apb(1'b1, OFS_RDSEL, 32'h0);
    cmd(32'h010, 32'd1670, ERR_CODE_NONE);
    rchk(OFS_RDAPER, 32'd1670);
    rchk(OFS_RDNPLC, 32'd1);
    cmd(32'h010, 32'd1669, ERR_CODE_PARAM);
    apb(1'b1, OFS_CHFUNC, 32'h0000_0101);
    apb(1'b1, OFS_CLIST, 32'h0001_0101);
    cmd(32'h100, 32'd300, ERR_CODE_NONE);
    apb(1'b1, OFS_CLIST, 32'h0002_0101);
    cmd(32'h100, 32'd300, ERR_CODE_CONFLICT);
    cmd(32'h202, 32'd1234, ERR_CODE_NONE);
    apb(1'b1, OFS_RDSEL, 32'h2);
    rchk(OFS_RDNPLC, 32'd1234);
    cmd(32'h002, 32'd2345, ERR_CODE_NONE);
    rchk(OFS_RDNPLC, 32'd2345);
    apb(1'b1, OFS_MASK, 32'h8);
    cmd(32'h030, 32'h102, ERR_CODE_NONE);
    chk({31'h0, irq}, 32'h0);
    conv(24'd100, 24'd201, 24'd150);
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, OFS_STATUS, 32'hF);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, OFS_CTRL, 32'h10);
    conv(24'd7, 24'd9, 24'd7);
    apb(1'b1, OFS_CTRL, 32'h0);
    repeat (40) @(posedge clk);
    conv(24'd100, 24'd201, 24'd150);
    apb(1'b1, OFS_CTRL, 32'h1);
    cmd(32'h000, 32'd6000, ERR_CODE_PARAM);
    rchk(OFS_RDAPER, 32'd200000);
    rchk(8'h34, 32'h0);
    chk({31'h0, serr}, 32'h1);
    finish_test();
  end
endmodule // tb
